// ### pkg/tlv_pkg.sv
// constants and types for the two-level vectored interrupt controller
package tlv_pkg;
  // source count and index width
  localparam int NUM_SRC = 19;
  localparam int IDX_W = 5;
  // register addresses on the special-function-register port
  localparam logic [7:0] ADDR_IE = 8'ha8;
  localparam logic [7:0] ADDR_IP = 8'hb8;
  localparam logic [7:0] ADDR_IRQ_ENABLE_EXT_ONE = 8'he6;
  localparam logic [7:0] ADDR_IRQ_ENABLE_EXT_TWO = 8'he7;
  localparam logic [7:0] ADDR_IRQ_PRIORITY_EXT_ONE = 8'hf6;
  localparam logic [7:0] ADDR_IRQ_PRIORITY_EXT_TWO = 8'hf7;
  // reset values and writable-bit masks
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] IP_WMASK = 8'h7f;
  localparam logic [7:0] EXT2_WMASK = 8'h0f;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PRIM_SRC_W = 7;
  localparam int EXT1_SRC_W = 8;
  localparam int EXT2_SRC_W = 4;
  // fixed sources
  localparam logic [IDX_W-1:0] SRC_SUPPLY_WARN = 5'h0f;
  localparam logic [NUM_SRC-1:0] AUTO_CLR_MASK = 19'h0000f;
  localparam logic [NUM_SRC-1:0] SW_RO_MASK = 19'h08000;
  // vector layout
  localparam logic [15:0] RESET_VEC = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
  // timing: clock period in ns, call length in system clocks
  localparam int CLK_PERIOD_NS = 100;
  localparam int LCALL_CYCLES = 5;
  localparam logic [2:0] LCALL_LAST = 3'(LCALL_CYCLES - 1);
  localparam logic [2:0] CNT_ZERO = 3'h0;
  // sequencer states
  typedef enum logic [1:0] {
    TLV_IDLE,
    TLV_REQ,
    TLV_CALL
  } tlv_state_t;
endpackage

// ### pkg/tlv_arb_if.sv
// carrier between the controller and its priority arbiter
`timescale 1ns/10ps
interface tlv_arb_if #(
  parameter int N = 19,
  parameter int W = 5
);
  logic [N-1:0] req;
  logic [N-1:0] high;
  logic win_valid;
  logic win_high;
  logic [W-1:0] win_idx;
  modport ctrl (output req, output high, input win_valid, input win_high,
                input win_idx);
  modport arb (input req, input high, output win_valid, output win_high,
               output win_idx);
endinterface

// ### src/tlv_arb.sv
// two-level priority arbiter with fixed order inside a level
`timescale 1ns/10ps
module tlv_arb #(
  parameter int N = 19,
  parameter int W = 5
) (
  tlv_arb_if.arb bus
);
  logic [N-1:0] hi_req;
  logic [N-1:0] sel;
  logic [W-1:0] idx;

  // high level first, then lowest index wins
  always_comb begin
    hi_req = bus.req & bus.high;
    sel = (|hi_req) ? hi_req : bus.req;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (sel[i]) begin
        idx = W'(i);
      end
    end
  end

  // winner outputs
  assign bus.win_valid = |bus.req;
  assign bus.win_high = |hi_req;
  assign bus.win_idx = idx;
endmodule

// ### src/tlv_ctrl.sv
// two-level vectored interrupt controller for an 8051-style core
`timescale 1ns/10ps
module tlv_ctrl #(
  parameter int N = tlv_pkg::NUM_SRC,
  parameter int W = tlv_pkg::IDX_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [N-1:0] src_event,
  input wire logic [N-1:0] flag_set,
  input wire logic [N-1:0] flag_clr,
  output logic [N-1:0] pend_flags,
  input wire logic cpu_instr_done,
  input wire logic cpu_reti,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [W-1:0] irq_src,
  output logic irq_high,
  output logic lcall_start,
  output logic service_start,
  output logic in_service_high,
  output logic in_service_low
);
  logic [7:0] en_prim;
  logic [7:0] pr_prim;
  logic [7:0] en_ext1;
  logic [7:0] pr_ext1;
  logic [7:0] en_ext2;
  logic [7:0] pr_ext2;
  logic global_irq_enable;
  logic [N-1:0] src_en;
  logic [N-1:0] src_hi;
  logic [N-1:0] eligible;
  logic [N-1:0] next_pend;
  logic [N-1:0] auto_clr;
  logic [N-1:0] below;
  tlv_pkg::tlv_state_t state;
  tlv_pkg::tlv_state_t next_state;
  logic [2:0] call_cnt;
  logic go;
  logic [15:0] win_vec;

  tlv_arb_if #(.N(N), .W(W)) arb_bus ();

  tlv_arb #(.N(N), .W(W)) u_arb (
    .bus(arb_bus)
  );

  // register writes; reserved bits stay zero
  always_ff @(posedge clk) begin
    if (rst) begin
      en_prim <= tlv_pkg::REG_RESET;
      pr_prim <= tlv_pkg::REG_RESET;
      en_ext1 <= tlv_pkg::REG_RESET;
      pr_ext1 <= tlv_pkg::REG_RESET;
      en_ext2 <= tlv_pkg::REG_RESET;
      pr_ext2 <= tlv_pkg::REG_RESET;
    end else if (sfr_wr) begin
      case (sfr_addr)
        tlv_pkg::ADDR_IE: en_prim <= sfr_wdata;
        tlv_pkg::ADDR_IP: pr_prim <= sfr_wdata & tlv_pkg::IP_WMASK;
        tlv_pkg::ADDR_IRQ_ENABLE_EXT_ONE: en_ext1 <= sfr_wdata;
        tlv_pkg::ADDR_IRQ_PRIORITY_EXT_ONE: pr_ext1 <= sfr_wdata;
        tlv_pkg::ADDR_IRQ_ENABLE_EXT_TWO: en_ext2 <= sfr_wdata & tlv_pkg::EXT2_WMASK;
        tlv_pkg::ADDR_IRQ_PRIORITY_EXT_TWO: pr_ext2 <= sfr_wdata & tlv_pkg::EXT2_WMASK;
        default: ;
      endcase
    end
  end

  // register read port, registered
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= tlv_pkg::RD_UNMAPPED;
    end else if (sfr_rd) begin
      case (sfr_addr)
        tlv_pkg::ADDR_IE: sfr_rdata <= en_prim;
        tlv_pkg::ADDR_IP: sfr_rdata <= pr_prim;
        tlv_pkg::ADDR_IRQ_ENABLE_EXT_ONE: sfr_rdata <= en_ext1;
        tlv_pkg::ADDR_IRQ_PRIORITY_EXT_ONE: sfr_rdata <= pr_ext1;
        tlv_pkg::ADDR_IRQ_ENABLE_EXT_TWO: sfr_rdata <= en_ext2;
        tlv_pkg::ADDR_IRQ_PRIORITY_EXT_TWO: sfr_rdata <= pr_ext2;
        default: sfr_rdata <= tlv_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // per-source enable and priority vectors
  assign global_irq_enable = en_prim[tlv_pkg::GLOBAL_EN_BIT];
  assign src_en = {en_ext2[tlv_pkg::EXT2_SRC_W-1:0], en_ext1,
                   en_prim[tlv_pkg::PRIM_SRC_W-1:0]};
  assign src_hi = {pr_ext2[tlv_pkg::EXT2_SRC_W-1:0], pr_ext1,
                   pr_prim[tlv_pkg::PRIM_SRC_W-1:0]};

  // per-source request gating, recomputed every clock
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_src
      assign eligible[gi] = pend_flags[gi] & src_en[gi]
        & global_irq_enable
        & (src_hi[gi] ? ~in_service_high
                      : ~(in_service_high | in_service_low));
    end
  endgenerate

  assign arb_bus.req = eligible;
  assign arb_bus.high = src_hi;

  // call begins at an instruction boundary with a live winner
  assign go = (state == tlv_pkg::TLV_REQ) && arb_bus.win_valid
    && cpu_instr_done;

  // hardware clear only for the pin and basic timer sources
  assign auto_clr = go ? (tlv_pkg::AUTO_CLR_MASK
    & (N'(1) << arb_bus.win_idx)) : '0;

  // pending flags: set beats any clear
  always_comb begin
    next_pend = pend_flags & ~flag_clr & ~auto_clr;
    next_pend = next_pend | src_event;
    next_pend = next_pend | (flag_set & ~tlv_pkg::SW_RO_MASK);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_flags <= '0;
    end else begin
      pend_flags <= next_pend;
    end
  end

  // vector of the current winner
  assign win_vec = 16'(tlv_pkg::VEC_BASE
    + 16'({11'h000, arb_bus.win_idx} * tlv_pkg::VEC_STEP));

  // request and call sequencer
  always_comb begin
    next_state = state;
    case (state)
      tlv_pkg::TLV_IDLE: begin
        if (arb_bus.win_valid) begin
          next_state = tlv_pkg::TLV_REQ;
        end
      end
      tlv_pkg::TLV_REQ: begin
        if (go) begin
          next_state = tlv_pkg::TLV_CALL;
        end else if (!arb_bus.win_valid) begin
          next_state = tlv_pkg::TLV_IDLE;
        end
      end
      tlv_pkg::TLV_CALL: begin
        if (call_cnt == tlv_pkg::CNT_ZERO) begin
          next_state = tlv_pkg::TLV_IDLE;
        end
      end
      default: next_state = tlv_pkg::TLV_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= tlv_pkg::TLV_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // five-clock long call countdown
  always_ff @(posedge clk) begin
    if (rst) begin
      call_cnt <= tlv_pkg::CNT_ZERO;
    end else if (go) begin
      call_cnt <= tlv_pkg::LCALL_LAST;
    end else if (call_cnt != tlv_pkg::CNT_ZERO) begin
      call_cnt <= call_cnt - 3'h1;
    end
  end

  // request flag and winner tracking, frozen during the call
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_req <= 1'b0;
      irq_vector <= tlv_pkg::RESET_VEC;
      irq_src <= '0;
      irq_high <= 1'b0;
    end else begin
      irq_req <= (next_state == tlv_pkg::TLV_REQ);
      if (state != tlv_pkg::TLV_CALL && arb_bus.win_valid) begin
        irq_vector <= win_vec;
        irq_src <= arb_bus.win_idx;
        irq_high <= arb_bus.win_high;
      end
    end
  end

  // call start and service entry pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      lcall_start <= 1'b0;
      service_start <= 1'b0;
    end else begin
      lcall_start <= go;
      service_start <= (state == tlv_pkg::TLV_CALL)
        && (call_cnt == tlv_pkg::CNT_ZERO);
    end
  end

  // nesting levels: entry on call, exit on return
  always_ff @(posedge clk) begin
    if (rst) begin
      in_service_high <= 1'b0;
      in_service_low <= 1'b0;
    end else if (go) begin
      if (arb_bus.win_high) begin
        in_service_high <= 1'b1;
      end else begin
        in_service_low <= 1'b1;
      end
    end else if (cpu_reti) begin
      if (in_service_high) begin
        in_service_high <= 1'b0;
      end else begin
        in_service_low <= 1'b0;
      end
    end
  end

  // helper: eligible sources of the winner's level below its index
  assign below = eligible & (arb_bus.win_high ? src_hi : ~src_hi)
    & ((N'(1) << arb_bus.win_idx) - N'(1));

  property p_ea_block;
    @(posedge clk) disable iff (rst)
      (!global_irq_enable && !sfr_wr) |=> !irq_req;
  endproperty
  a_ea_block: assert property (p_ea_block)
    else $error("request raised while globally disabled");

  property p_hold_pending;
    @(posedge clk) disable iff (rst)
      (!global_irq_enable && flag_clr == '0)
      |=> ((pend_flags & $past(pend_flags)) == $past(pend_flags));
  endproperty
  a_hold_pending: assert property (p_hold_pending)
    else $error("pending flag lost while globally disabled");

  property p_call_timing;
    @(posedge clk) disable iff (rst)
      go |=> lcall_start ##5 service_start;
  endproperty
  a_call_timing: assert property (p_call_timing)
    else $error("long call did not take five clocks");

  property p_no_preempt_hi;
    @(posedge clk) disable iff (rst)
      in_service_high |=> !lcall_start;
  endproperty
  a_no_preempt_hi: assert property (p_no_preempt_hi)
    else $error("high service routine was preempted");

  property p_level_first;
    @(posedge clk) disable iff (rst)
      (|(eligible & src_hi)) |-> arb_bus.win_high;
  endproperty
  a_level_first: assert property (p_level_first)
    else $error("low level won over a high request");

  property p_fixed_order;
    @(posedge clk) disable iff (rst)
      arb_bus.win_valid |-> (below == '0);
  endproperty
  a_fixed_order: assert property (p_fixed_order)
    else $error("winner is not the lowest index of its level");

  property p_auto_clear;
    @(posedge clk) disable iff (rst)
      (go && arb_bus.win_idx < W'(4) && src_event == '0 && flag_set == '0)
      |=> !pend_flags[irq_src];
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("pin or timer flag not cleared on vectoring");

  property p_supply_ro;
    @(posedge clk) disable iff (rst)
      (!pend_flags[tlv_pkg::SRC_SUPPLY_WARN]
        && !src_event[tlv_pkg::SRC_SUPPLY_WARN])
      |=> !pend_flags[tlv_pkg::SRC_SUPPLY_WARN];
  endproperty
  a_supply_ro: assert property (p_supply_ro)
    else $error("software set the read-only supply warning flag");

  property p_vector;
    @(posedge clk) disable iff (rst)
      irq_req |-> (irq_vector == 16'(tlv_pkg::VEC_BASE
        + 16'({11'h000, irq_src} * tlv_pkg::VEC_STEP)));
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector does not match source index");

  property p_resume_low;
    @(posedge clk) disable iff (rst)
      (cpu_reti && in_service_high && !go) |=>
        (!in_service_high && in_service_low == $past(in_service_low));
  endproperty
  a_resume_low: assert property (p_resume_low)
    else $error("return from high routine disturbed low level");
endmodule

// ### tb/tlv_cpu_model.sv
// cpu pipeline stand-in: instruction pacing, vectoring call and return
`timescale 1ns/10ps
module tlv_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq_req,
  input wire logic lcall_start,
  input wire logic service_start,
  input wire logic reti_req,
  input wire logic [3:0] instr_len,
  output logic cpu_instr_done,
  output logic cpu_reti
);
  logic in_call;
  logic reti_pend;
  logic reti_go;
  logic [3:0] cnt;
  // the pending flag clears one edge after the pulse; block a second pulse
  assign reti_go = reti_pend && !cpu_reti;
  // no instruction retires while the vectoring call runs
  always_ff @(posedge clk) begin
    if (rst || service_start) begin
      in_call <= 1'b0;
    end else if (lcall_start) begin
      in_call <= 1'b1;
    end
  end
  // a requested return waits for the next instruction slot
  always_ff @(posedge clk) begin
    if (rst || cpu_reti) begin
      reti_pend <= 1'b0;
    end else if (reti_req) begin
      reti_pend <= 1'b1;
    end
  end
  // one instruction every instr_len cycles, long ones for slow answers
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 4'h0;
      cpu_instr_done <= 1'b0;
      cpu_reti <= 1'b0;
    end else begin
      cpu_instr_done <= 1'b0;
      cpu_reti <= 1'b0;
      if (in_call || lcall_start || (cpu_instr_done && irq_req)) begin
        cnt <= 4'h0;
      end else if (cnt + 4'h1 >= instr_len) begin
        cnt <= 4'h0;
        cpu_reti <= reti_go;
        cpu_instr_done <= !reti_go;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// ### tb/tlv_ctrl_bench.sv
// randomised self-checking bench for the interrupt controller
`timescale 1ns/10ps
module tlv_ctrl_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic reti_req = 1'b0;
  logic exp_high = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [18:0] src_event = 19'h0;
  logic [18:0] flag_set = 19'h0;
  logic [18:0] flag_clr = 19'h0;
  logic [18:0] pend_flags, m;
  logic cpu_instr_done, cpu_reti, irq_req, irq_high, lcall_start;
  logic service_start, in_service_high, in_service_low, seen_done;
  logic [15:0] irq_vector;
  logic [4:0] irq_src;
  logic [4:0] exp_src = 5'h0;
  logic [3:0] instr_len = 4'h1;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int call_cyc = 0;
  int t0, done_at, s;
  logic [7:0] addrs [6] = '{tlv_pkg::ADDR_IE, tlv_pkg::ADDR_IP,
    tlv_pkg::ADDR_IRQ_ENABLE_EXT_ONE, tlv_pkg::ADDR_IRQ_PRIORITY_EXT_ONE, tlv_pkg::ADDR_IRQ_ENABLE_EXT_TWO,
    tlv_pkg::ADDR_IRQ_PRIORITY_EXT_TWO};
  logic [7:0] masks [6] = '{8'hff, tlv_pkg::IP_WMASK, 8'hff, 8'hff,
    tlv_pkg::EXT2_WMASK, tlv_pkg::EXT2_WMASK};

  tlv_ctrl i_dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .src_event(src_event), .flag_set(flag_set),
    .flag_clr(flag_clr), .pend_flags(pend_flags),
    .cpu_instr_done(cpu_instr_done), .cpu_reti(cpu_reti),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_src(irq_src),
    .irq_high(irq_high), .lcall_start(lcall_start),
    .service_start(service_start), .in_service_high(in_service_high),
    .in_service_low(in_service_low));
  tlv_cpu_model i_cpu (.clk(clk), .rst(rst), .irq_req(irq_req),
    .lcall_start(lcall_start), .service_start(service_start),
    .reti_req(reti_req), .instr_len(instr_len),
    .cpu_instr_done(cpu_instr_done), .cpu_reti(cpu_reti));

  // clock
  always #50 clk = ~clk;

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    check("sfr_rdata", 16'(sfr_rdata), 16'(exp));
  endtask

  // kind 0 hardware event, 1 software set, 2 software clear
  task automatic pulse(int kind, logic [18:0] v);
    @(negedge clk);
    if (kind == 0) src_event = v;
    else if (kind == 1) flag_set = v;
    else flag_clr = v;
    @(negedge clk);
    src_event = 19'h0;
    flag_set = 19'h0;
    flag_clr = 19'h0;
  endtask

  task automatic serve(logic [4:0] r, logic h);
    exp_src = r;
    exp_high = h;
    repeat (40) begin
      @(negedge clk);
      if (lcall_start) break;
    end
    check("lcall_start", 16'(lcall_start), 16'h1);
    repeat (5) @(negedge clk);
    done_at = cycles;
    @(negedge clk);
  endtask

  task automatic ret(logic [4:0] r, logic clr);
    if (clr) pulse(2, 19'h1 << r);
    @(negedge clk);
    reti_req = 1'b1;
    @(negedge clk);
    reti_req = 1'b0;
    repeat (30) begin
      if (cpu_reti) break;
      @(negedge clk);
    end
    t0 = cycles;
    @(negedge clk);
  endtask

  // cycle count and run limit
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      conclude();
    end
  end

  // per-call checks on winner, vector, call length and retire order,
  // sampled mid-cycle once the outputs have settled
  always @(negedge clk) begin
    if (rst) seen_done = 1'b1;
    else begin
      if (lcall_start) begin
        check("irq_src", 16'(irq_src), 16'(exp_src));
        check("irq_vector", irq_vector,
          tlv_pkg::VEC_BASE + tlv_pkg::VEC_STEP * exp_src);
        check("irq_high", 16'(irq_high), 16'(exp_high));
        check("retired", 16'(seen_done), 16'h1);
        check("auto_clr", 16'(pend_flags[exp_src]), 16'(exp_src > 3));
      end
      call_cyc = lcall_start ? 0 : call_cyc + 1;
      if (service_start) check("call_len", 16'(call_cyc), 16'h5);
      if (cpu_reti) seen_done = 1'b0;
      if (cpu_instr_done) seen_done = 1'b1;
    end
  end

  // main sequence
  initial begin
    void'($urandom(90328));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check("irq_vector", irq_vector, tlv_pkg::RESET_VEC);
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    rd(8'h55, tlv_pkg::RD_UNMAPPED);
    foreach (addrs[i]) begin
      wr(addrs[i], 8'hff);
      rd(addrs[i], masks[i]);
      wr(addrs[i], 8'h00);
    end
    wr(tlv_pkg::ADDR_IRQ_ENABLE_EXT_ONE, 8'hff);
    wr(tlv_pkg::ADDR_IRQ_ENABLE_EXT_TWO, 8'h0f);
    wr(tlv_pkg::ADDR_IE, 8'h7f);
    pulse(0, 19'h10);
    repeat (5) @(negedge clk);
    check("irq_req", 16'(irq_req), 16'h0);
    check("pend4", 16'(pend_flags[4]), 16'h1);
    wr(tlv_pkg::ADDR_IE, 8'h80);
    repeat (3) @(negedge clk);
    check("irq_req", 16'(irq_req), 16'h0);
    wr(tlv_pkg::ADDR_IE, 8'hff);
    serve(5'h4, 1'b0);
    ret(5'h4, 1'b1);
    pulse(0, 19'h2);
    t0 = cycles;
    serve(5'h1, 1'b0);
    check("latency", 16'(done_at - t0), 16'h7);
    ret(5'h1, 1'b1);
    pulse(0, 19'h20);
    serve(5'h5, 1'b0);
    ret(5'h5, 1'b0);
    serve(5'h5, 1'b0);
    pulse(0, 19'h40);
    repeat (4) @(negedge clk);
    check("irq_req", 16'(irq_req), 16'h0);
    instr_len = 4'h8;
    ret(5'h5, 1'b1);
    serve(5'h6, 1'b0);
    check("worst", 16'(done_at - t0 <= 19), 16'h1);
    instr_len = 4'h1;
    ret(5'h6, 1'b1);
    wr(tlv_pkg::ADDR_IRQ_PRIORITY_EXT_ONE, 8'h18);
    pulse(1, 19'h00404);
    serve(5'ha, 1'b1);
    check("hi_busy", 16'(in_service_high), 16'h1);
    check("irq_req", 16'(irq_req), 16'h0);
    ret(5'ha, 1'b1);
    serve(5'h2, 1'b0);
    pulse(0, 19'h00400);
    serve(5'ha, 1'b1);
    pulse(0, 19'h00800);
    repeat (3) @(negedge clk);
    check("irq_req", 16'(irq_req), 16'h0);
    ret(5'ha, 1'b1);
    serve(5'hb, 1'b1);
    ret(5'hb, 1'b1);
    check("lo_busy", 16'(in_service_low), 16'h1);
    check("hi_busy", 16'(in_service_high), 16'h0);
    ret(5'h2, 1'b1);
    wr(tlv_pkg::ADDR_IRQ_PRIORITY_EXT_ONE, 8'h00);
    wr(tlv_pkg::ADDR_IRQ_ENABLE_EXT_TWO, 8'h0e);
    pulse(1, 19'h08000);
    check("pend15", 16'(pend_flags[15]), 16'h0);
    pulse(0, 19'h08000);
    repeat (3) @(negedge clk);
    check("irq_req", 16'(irq_req), 16'h0);
    pulse(2, 19'h08000);
    wr(tlv_pkg::ADDR_IRQ_ENABLE_EXT_TWO, 8'h0f);
    for (int r = 0; r < 6; r++) begin
      m = (r == 0) ? 19'h40000 : 19'($urandom) & 19'h77fff;
      instr_len = 4'($urandom_range(8, 1));
      pulse(1, m);
      while (m != 19'h0) begin
        s = 0;
        while (!m[s]) s++;
        serve(5'(s), 1'b0);
        m[s] = 1'b0;
        ret(5'(s), 1'b1);
      end
    end
    conclude();
  end
endmodule
